//--- core/trf_pkg.sv
/*
 package for the timing reference failover block: register map, field
 positions, reset values, timing constants and carrier types.
 assumes a 50 MHz module clock and an AXI4-Lite register bus.
*/
package trf_pkg;

	localparam int CLK_HZ = 50_000_000;
	localparam int CLK_NS = 20;

	// source codes
	typedef enum logic [1:0] {
		TRF_SRC_LOCAL = 2'h0,
		TRF_SRC_BUS1 = 2'h1,
		TRF_SRC_BUS2 = 2'h2,
		TRF_SRC_OSC = 2'h3
	} trf_src_type;

	typedef enum logic [1:0] {
		TRF_ST_PRIMARY = 2'h0,
		TRF_ST_SECONDARY = 2'h1,
		TRF_ST_HOLDOFF = 2'h2
	} trf_state_type;

	// register byte offsets
	localparam logic [7:0] TRF_CTRL_OFS = 8'h00;
	localparam logic [7:0] TRF_DELAY_OFS = 8'h04;
	localparam logic [7:0] TRF_STATUS_OFS = 8'h08;
	localparam logic [7:0] TRF_PHASE_OFS = 8'h0C;

	// control fields
	localparam int TRF_CTRL_PRI_LSB = 0;
	localparam int TRF_CTRL_SEC_LSB = 2;
	localparam int TRF_CTRL_AUTO_BIT = 4;
	localparam int TRF_CTRL_CMD_BIT = 5;
	localparam logic [4:0] TRF_CTRL_RESET = 5'h04;

	// switchback delay, seconds
	localparam int TRF_MIN_DELAY_S = 30;
	localparam logic [7:0] TRF_DELAY_RESET = 8'h1E;

	// phase grading limits
	localparam int TRF_PHASE_OK_NS = 72;
	localparam int TRF_PHASE_SPAN_NS = 1000;
	localparam logic [5:0] TRF_PHASE_OK_CYC = 6'(TRF_PHASE_OK_NS / CLK_NS);
	localparam logic [5:0] TRF_PHASE_SPAN_CYC = 6'(TRF_PHASE_SPAN_NS / CLK_NS);

	localparam logic [1:0] TRF_RESP_OKAY = 2'h0;
	localparam logic [1:0] TRF_RESP_SLVERR = 2'h2;

	// one candidate source as seen from outside
	typedef struct packed {
		logic present;
		logic locked;
		logic tick;
	} trf_ref_type;

endpackage

//--- core/trf_failover.sv
/*
 timing reference failover: picks the output reference from four sources,
 fails over to the secondary, switches back after a delay, grades phase.
 assumes reference status/tick pins are asynchronous to clk and the
 phase ticks are frame pulses at least a few clock cycles wide.
*/
`timescale 1ns/1ps

// Contract
// - primary and secondary chosen independently
// - report presence and lock per source
// - fail over when primary lost
// - same selection means no failover
// - manual or automatic switchback mode
// - auto switchback waits delay, minimum thirty seconds
// - phase within 72 ns graded green
// - larger phase raises red indication
// - phase indication spans about one microsecond
module trf_failover #(
	parameter int TICKS_PER_SEC = trf_pkg::CLK_HZ
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire trf_pkg::trf_ref_type [2:0] ref_in,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [1:0] sel_src,
	output logic on_secondary,
	output logic phase_green,
	output logic phase_red
);
	logic [8:0] sync1_reg;
	logic [8:0] sync2_reg;
	logic [2:0] tick_d_reg;
	logic [4:0] ctrl_reg;
	logic [7:0] delay_reg;
	trf_pkg::trf_state_type state_reg;
	trf_pkg::trf_state_type state_next;
	logic [25:0] sub_reg;
	logic [7:0] sec_reg;
	logic [5:0] phase_cnt_reg;
	logic phase_run_reg;
	logic [5:0] phase_reg;
	logic cmd_reg;
	logic aw_hold_reg;
	logic w_hold_reg;
	logic [7:0] aw_addr_reg;
	logic [31:0] w_data_reg;
	logic w_strb0_reg;
	function automatic logic src_ok(input logic [1:0] src, input logic [8:0] s);
		return (src == 2'h3) || (s[3 * src + 2] && s[3 * src + 1]);
	endfunction

	wire [8:0] ref_flat = ref_in;
	wire [1:0] pri_sel = ctrl_reg[trf_pkg::TRF_CTRL_PRI_LSB +: 2];
	wire [1:0] sec_sel = ctrl_reg[trf_pkg::TRF_CTRL_SEC_LSB +: 2];
	wire auto_mode = ctrl_reg[trf_pkg::TRF_CTRL_AUTO_BIT];
	wire pri_ok = src_ok(pri_sel, sync2_reg);
	wire sec_ok = src_ok(sec_sel, sync2_reg);
	wire fo_enable = pri_sel != sec_sel;
	wire sec_tick_done = sub_reg == 26'(TICKS_PER_SEC - 1);
	wire [7:0] delay_eff = (delay_reg < 8'(trf_pkg::TRF_MIN_DELAY_S)) ?
		8'(trf_pkg::TRF_MIN_DELAY_S) : delay_reg;
	wire delay_done = sec_tick_done && (sec_reg == delay_eff - 8'h01);
	wire [2:0] tick_now = {sync2_reg[6], sync2_reg[3], sync2_reg[0]};
	wire [2:0] tick_rise = tick_now & ~tick_d_reg;
	wire pri_edge = (pri_sel == 2'h3) ? 1'b0 : tick_rise[pri_sel];
	wire sec_edge = (sec_sel == 2'h3) ? 1'b0 : tick_rise[sec_sel];
	wire aw_take = s_axi_awvalid && s_axi_awready;
	wire w_take = s_axi_wvalid && s_axi_wready;
	wire wr_go = aw_hold_reg && w_hold_reg && !s_axi_bvalid;
	wire wr_ctrl = wr_go && aw_addr_reg == trf_pkg::TRF_CTRL_OFS;
	wire wr_delay = wr_go && aw_addr_reg == trf_pkg::TRF_DELAY_OFS;
	wire wr_hit = wr_ctrl || wr_delay;
	wire [7:0] ar_addr = s_axi_araddr[7:0];
	wire [31:0] status_word = {22'h0, state_reg, sel_src, sync2_reg[7], sync2_reg[8],
		sync2_reg[4], sync2_reg[5], sync2_reg[1], sync2_reg[2]};
	wire [31:0] rd_word =
		(ar_addr == trf_pkg::TRF_CTRL_OFS) ? {27'h0, ctrl_reg} :
		(ar_addr == trf_pkg::TRF_DELAY_OFS) ? {24'h0, delay_reg} :
		(ar_addr == trf_pkg::TRF_STATUS_OFS) ? status_word :
		{24'h0, phase_red, phase_green, phase_reg};
	wire rd_hit = ar_addr == trf_pkg::TRF_CTRL_OFS || ar_addr == trf_pkg::TRF_DELAY_OFS ||
		ar_addr == trf_pkg::TRF_STATUS_OFS || ar_addr == trf_pkg::TRF_PHASE_OFS;
	always_ff @(posedge clk) begin
		if (ce) begin
			sync1_reg <= ref_flat;
			sync2_reg <= sync1_reg;
			tick_d_reg <= tick_now;
		end
	end
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			trf_pkg::TRF_ST_PRIMARY: begin
				if (fo_enable && !pri_ok && sec_ok) begin
					state_next = trf_pkg::TRF_ST_SECONDARY;
				end
			end
			trf_pkg::TRF_ST_SECONDARY: begin
				if (!fo_enable) begin
					state_next = trf_pkg::TRF_ST_PRIMARY;
				end else if (pri_ok && auto_mode) begin
					state_next = trf_pkg::TRF_ST_HOLDOFF;
				end else if (pri_ok && cmd_reg) begin
					state_next = trf_pkg::TRF_ST_PRIMARY;
				end
			end
			trf_pkg::TRF_ST_HOLDOFF: begin
				if (!fo_enable) begin
					state_next = trf_pkg::TRF_ST_PRIMARY;
				end else if (!pri_ok || !auto_mode) begin
					state_next = trf_pkg::TRF_ST_SECONDARY;
				end else if (delay_done) begin
					state_next = trf_pkg::TRF_ST_PRIMARY;
				end
			end
			default: state_next = trf_pkg::TRF_ST_PRIMARY;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_reg <= trf_pkg::TRF_ST_PRIMARY;
		end else if (ce) begin
			state_reg <= state_next;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n || (ce && state_next != trf_pkg::TRF_ST_HOLDOFF)) begin
			sub_reg <= 26'h0;
			sec_reg <= 8'h0;
		end else if (ce) begin
			sub_reg <= sec_tick_done ? 26'h0 : sub_reg + 26'h1;
			sec_reg <= sec_reg + 8'(sec_tick_done);
		end
	end
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sel_src <= trf_pkg::TRF_CTRL_RESET[1:0];
			on_secondary <= 1'b0;
		end else if (ce) begin
			sel_src <= (state_next == trf_pkg::TRF_ST_PRIMARY) ? pri_sel : sec_sel;
			on_secondary <= state_next != trf_pkg::TRF_ST_PRIMARY;
		end
	end

	// phase between primary and secondary ticks
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			phase_run_reg <= 1'b0;
			phase_cnt_reg <= 6'h0;
			phase_reg <= 6'h0;
			phase_green <= 1'b0;
			phase_red <= 1'b0;
		end else if (ce) begin
			if (pri_edge != sec_edge && !phase_run_reg) begin
				phase_run_reg <= 1'b1;
				phase_cnt_reg <= 6'h1;
			end else if (phase_run_reg && (pri_edge || sec_edge ||
				phase_cnt_reg == trf_pkg::TRF_PHASE_SPAN_CYC)) begin
				phase_run_reg <= 1'b0;
				phase_reg <= phase_cnt_reg;
				phase_green <= phase_cnt_reg <= trf_pkg::TRF_PHASE_OK_CYC;
				phase_red <= phase_cnt_reg > trf_pkg::TRF_PHASE_OK_CYC;
			end else if (pri_edge && sec_edge) begin
				phase_reg <= 6'h0;
				phase_green <= 1'b1;
				phase_red <= 1'b0;
			end else if (phase_run_reg) begin
				phase_cnt_reg <= phase_cnt_reg + 6'h1;
			end
		end
	end

	// axi-lite write path
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			aw_hold_reg <= 1'b0;
			w_hold_reg <= 1'b0;
			aw_addr_reg <= 8'h0;
			w_data_reg <= 32'h0;
			w_strb0_reg <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= trf_pkg::TRF_RESP_OKAY;
			ctrl_reg <= trf_pkg::TRF_CTRL_RESET;
			delay_reg <= trf_pkg::TRF_DELAY_RESET;
			cmd_reg <= 1'b0;
		end else if (ce) begin
			s_axi_awready <= wr_go || !(aw_hold_reg || aw_take);
			s_axi_wready <= wr_go || !(w_hold_reg || w_take);
			if (aw_take) begin
				aw_hold_reg <= 1'b1;
				aw_addr_reg <= s_axi_awaddr[7:0];
			end
			if (w_take) begin
				w_hold_reg <= 1'b1;
				w_data_reg <= s_axi_wdata;
				w_strb0_reg <= s_axi_wstrb[0];
			end
			if (wr_go) begin
				aw_hold_reg <= 1'b0;
				w_hold_reg <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_hit ? trf_pkg::TRF_RESP_OKAY : trf_pkg::TRF_RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
			cmd_reg <= wr_ctrl && w_strb0_reg && w_data_reg[trf_pkg::TRF_CTRL_CMD_BIT];
			if (wr_ctrl && w_strb0_reg) begin
				ctrl_reg <= w_data_reg[4:0];
			end
			if (wr_delay && w_strb0_reg) begin
				delay_reg <= w_data_reg[7:0];
			end
		end
	end

	// axi-lite read path
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= trf_pkg::TRF_RESP_OKAY;
		end else if (ce) begin
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
			if (s_axi_arready && s_axi_arvalid) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_word;
				s_axi_rresp <= rd_hit ? trf_pkg::TRF_RESP_OKAY : trf_pkg::TRF_RESP_SLVERR;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	AST_NO_FO_SAME: assert property (@(posedge clk) disable iff (!rst_n)
		ce && !fo_enable |=> !on_secondary) else $error("failover with equal selections");
	AST_FAILOVER: assert property (@(posedge clk) disable iff (!rst_n)
		ce && state_reg == trf_pkg::TRF_ST_PRIMARY && fo_enable && !pri_ok && sec_ok
		|=> on_secondary && sel_src == $past(sec_sel)) else $error("failover missed");
	AST_DELAY_FLOOR: assert property (@(posedge clk) disable iff (!rst_n)
		state_reg == trf_pkg::TRF_ST_HOLDOFF && state_next == trf_pkg::TRF_ST_PRIMARY
		&& fo_enable |-> sec_reg >= 8'(trf_pkg::TRF_MIN_DELAY_S - 1))
		else $error("switchback too early");
	AST_ABANDON: assert property (@(posedge clk) disable iff (!rst_n)
		ce && state_reg == trf_pkg::TRF_ST_HOLDOFF && fo_enable && !pri_ok
		|=> state_reg == trf_pkg::TRF_ST_SECONDARY && sec_reg == 8'h0)
		else $error("switchback not abandoned");
	AST_MANUAL: assert property (@(posedge clk) disable iff (!rst_n)
		ce && state_reg == trf_pkg::TRF_ST_SECONDARY && !auto_mode && !cmd_reg && fo_enable
		|=> state_reg == trf_pkg::TRF_ST_SECONDARY) else $error("manual return without command");
	AST_GRADE: assert property (@(posedge clk) disable iff (!rst_n)
		!(phase_green && phase_red)) else $error("phase both green and red");
	AST_RED: assert property (@(posedge clk) disable iff (!rst_n)
		phase_red |-> phase_reg > trf_pkg::TRF_PHASE_OK_CYC) else $error("red under limit");
	AST_SPAN: assert property (@(posedge clk) disable iff (!rst_n)
		phase_reg <= trf_pkg::TRF_PHASE_SPAN_CYC) else $error("phase over span");
	AST_SEL: assert property (@(posedge clk) disable iff (!rst_n)
		ce |=> sel_src == (on_secondary ? $past(sec_sel) : $past(pri_sel)))
		else $error("wrong source selected");

	COV_FAILOVER: cover property (@(posedge clk) disable iff (!rst_n) !on_secondary ##1 on_secondary);
	COV_AUTO_BACK: cover property (@(posedge clk) disable iff (!rst_n)
		state_reg == trf_pkg::TRF_ST_HOLDOFF ##1 state_reg == trf_pkg::TRF_ST_PRIMARY);
	COV_RED: cover property (@(posedge clk) disable iff (!rst_n) phase_red);

endmodule // trf_failover

//--- dv/trf_ref_model.sv
/*
 reference source model: status levels and frame ticks of three sources.
 assumes the bench sets levels and tick lags by nonblocking assignment.
*/
`timescale 1ns/1ps
module trf_ref_model (
	input wire logic clk,
	input wire logic [2:0] pres,
	input wire logic [2:0] lock,
	input wire logic [2:0][7:0] lag,
	output trf_pkg::trf_ref_type [2:0] ref_out
);
	int cnt = 0;
	always @(posedge clk) begin
		cnt <= (cnt + 1) % 200;
	end
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			ref_out[i].present = pres[i];
			ref_out[i].locked = pres[i] & lock[i];
			// absent source sends no frame pulse
			ref_out[i].tick = pres[i] && ((cnt + 200 - int'(lag[i])) % 200) < 4;
		end
	end
endmodule // trf_ref_model

//--- dv/trf_failover_bench.sv
/*
 self-checking bench for the failover block: failover, switchback, phase.
 assumes TICKS_PER_SEC of 4, so one second is four clock cycles.
*/
`timescale 1ns/1ps
module trf_failover_bench;
	localparam logic [7:0] CT = trf_pkg::TRF_CTRL_OFS;
	localparam logic [7:0] DL = trf_pkg::TRF_DELAY_OFS;
	logic clk, rst_n, ce, aw_v, aw_r, w_v, w_r, b_v, b_r, ar_v, ar_r, r_v, r_r, on_sec, grn, red;
	logic [31:0] aw_a, w_d, ar_a, r_d, v;
	logic [3:0] w_s;
	logic [1:0] b_resp, r_resp, sel, resp;
	logic [2:0] pres, lock;
	logic [2:0][7:0] lag;
	logic [7:0] tab [4] = '{8'h00, 8'h03, 8'h04, 8'h50};
	trf_pkg::trf_ref_type [2:0] refs;
	int fail_count = 0;
	int check_count = 0;
	int cyc = 0;
	trf_ref_model MDL (.clk(clk), .pres(pres), .lock(lock), .lag(lag), .ref_out(refs));
	trf_failover #(.TICKS_PER_SEC(4)) DUT (.clk(clk), .rst_n(rst_n), .ce(ce), .ref_in(refs),
		.s_axi_awaddr(aw_a), .s_axi_awvalid(aw_v), .s_axi_awready(aw_r), .s_axi_wdata(w_d),
		.s_axi_wstrb(w_s), .s_axi_wvalid(w_v), .s_axi_wready(w_r), .s_axi_bresp(b_resp),
		.s_axi_bvalid(b_v), .s_axi_bready(b_r), .s_axi_araddr(ar_a), .s_axi_arvalid(ar_v),
		.s_axi_arready(ar_r), .s_axi_rdata(r_d), .s_axi_rresp(r_resp), .s_axi_rvalid(r_v),
		.s_axi_rready(r_r), .sel_src(sel), .on_secondary(on_sec), .phase_green(grn),
		.phase_red(red));
	initial begin
		clk = 0;
		forever #10 clk = ~clk;
	end
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 10000) begin
			fail_count++;
			wrap_up;
		end
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
		check_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value t=%0t %s: %h not %h", $time, m, seen, exp);
		end
	endtask
	function automatic logic [31:0] sexp(input logic [2:0] p, input logic [2:0] l);
		sexp = 32'h0;
		for (int i = 0; i < 3; i++) begin
			sexp[2 * i] = p[i];
			sexp[2 * i + 1] = p[i] & l[i];
		end
	endfunction
	function automatic logic [31:0] pexp(input logic [7:0] l);
		if (l <= 8'h03) return {24'h0, 2'h1, l[5:0]};
		return {24'h0, 2'h2, (l > 8'h32) ? 6'h32 : l[5:0]};
	endfunction
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic ah, wh, bh;
		bh = 0;
		@(posedge clk);
		aw_a <= {24'h000000, a};
		w_d <= d;
		aw_v <= 1'b1;
		w_v <= 1'b1;
		b_r <= 1'b1;
		while (!bh) begin
			@(negedge clk);
			ah = aw_v & aw_r;
			wh = w_v & w_r;
			bh = b_v;
			resp = b_resp;
			@(posedge clk);
			if (ah) aw_v <= 1'b0;
			if (wh) w_v <= 1'b0;
		end
		b_r <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		logic ah, rh;
		rh = 0;
		@(posedge clk);
		ar_a <= {24'h000000, a};
		ar_v <= 1'b1;
		r_r <= 1'b1;
		while (!rh) begin
			@(negedge clk);
			ah = ar_v & ar_r;
			rh = r_v;
			v = r_d;
			resp = r_resp;
			@(posedge clk);
			if (ah) ar_v <= 1'b0;
		end
		r_r <= 1'b0;
	endtask
	task automatic w8(input int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask
	task automatic pin(input int i, input logic b);
		@(posedge clk);
		lock[i] <= b;
	endtask
	task automatic rst;
		@(posedge clk);
		rst_n <= 1'b0;
		pres <= 3'h7;
		lock <= 3'h7;
		lag <= '0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
	endtask
	initial begin
		{rst_n, aw_v, w_v, b_r, ar_v, r_r, aw_a, w_d, ar_a} = '0;
		ce = 1'b1;
		w_s = 4'hF;
		pres = 3'h7;
		lock = 3'h7;
		lag = '0;
		v = $urandom(72);
		rst;
		rd(CT);
		chk(v, 32'h00000004, "ctrl reset");
		rd(DL);
		chk(v, 32'h0000001E, "delay reset");
		rd(8'h10);
		chk(32'(resp), 32'h00000002, "unmapped read");
		wr(8'h10, 32'hFFFFFFFF);
		chk(32'(resp), 32'h00000002, "unmapped write");
		rd(CT);
		chk(v, 32'h00000004, "unmapped no effect");
		w_s <= 4'h0;
		wr(DL, 32'h00000055);
		w_s <= 4'hF;
		rd(DL);
		chk(v, 32'h0000001E, "strobe off");
		wr(DL, 32'h00000028);
		rd(DL);
		chk(v, 32'h00000028, "delay write");
		$display("done: registers");
		// oscillator taken as a test source too, but never failed
		for (int p = 0; p < 4; p++) begin
			rst;
			wr(CT, 32'(p + 4 * ((p + 1) % 4)));
			w8(8);
			chk(32'(sel), 32'(p), "primary");
			if (p < 3) begin
				pin(p, 1'b0);
				w8(8);
				chk(32'(sel), 32'((p + 1) % 4), "failover");
				chk(32'(on_sec), 32'h00000001, "on secondary");
			end
		end
		repeat (4) begin
			@(posedge clk);
			pres <= 3'($urandom);
			lock <= 3'($urandom);
			w8(6);
			rd(trf_pkg::TRF_STATUS_OFS);
			chk(v & 32'h0000003F, sexp(pres, lock), "status");
		end
		$display("done: selection");
		rst;
		pin(0, 1'b0);
		w8(8);
		chk(32'(sel), 32'h00000001, "manual fail");
		pin(0, 1'b1);
		w8(200);
		chk(32'(sel), 32'h00000001, "manual hold");
		wr(CT, 32'h00000024);
		w8(8);
		chk(32'(sel), 32'h00000000, "manual back");
		chk(32'(on_sec), 32'h00000000, "manual back");
		@(posedge clk);
		ce <= 1'b0;
		pin(0, 1'b0);
		w8(8);
		chk(32'(sel), 32'h00000000, "frozen");
		@(posedge clk);
		ce <= 1'b1;
		w8(8);
		chk(32'(sel), 32'h00000001, "thawed");
		wr(CT, 32'h0000000A);
		pin(2, 1'b0);
		w8(8);
		chk(32'(sel), 32'h00000002, "same source");
		chk(32'(on_sec), 32'h00000000, "same source");
		$display("done: manual");
		rst;
		wr(DL, $urandom % 30);
		wr(CT, 32'h00000014);
		pin(0, 1'b0);
		w8(8);
		pin(0, 1'b1);
		w8(60);
		rd(trf_pkg::TRF_STATUS_OFS);
		chk((v >> 8) & 32'h00000003, 32'(trf_pkg::TRF_ST_HOLDOFF), "holdoff");
		pin(0, 1'b0);
		w8(10);
		chk(32'(sel), 32'h00000001, "relock loss");
		rd(trf_pkg::TRF_STATUS_OFS);
		chk((v >> 8) & 32'h00000003, 32'(trf_pkg::TRF_ST_SECONDARY), "abandoned");
		pin(0, 1'b1);
		w8(100);
		chk(32'(sel), 32'h00000001, "delay running");
		w8(40);
		chk(32'(sel), 32'h00000000, "auto back");
		$display("done: auto");
		rst;
		foreach (tab[k]) begin
			@(posedge clk);
			lag[1] <= tab[k];
			w8(500);
			rd(trf_pkg::TRF_PHASE_OFS);
			chk(v & 32'h000000FF, pexp(tab[k]), "phase");
			chk(32'({red, grn}), pexp(tab[k]) >> 6, "flags");
		end
		$display("done: phase");
		wrap_up;
	end
endmodule // trf_failover_bench
